// >>> common/irs_link_if.sv
// two-wire open-drain link between the bus master end and the slave end
// assumes external pull-ups: a line is low only while some end drives it
`timescale 1ns/1ps
`default_nettype none
interface irs_link_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // ==========================================================
  // wired-and resolution with pull-up
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input sda);
  modport slave (output s_sda_o, s_sda_oe, input scl, sda);
endinterface
`default_nettype wire

// >>> common/irs_pkg.sv
// constants and types shared by both ends of the register slave link
// assumes a 40 MHz system clock on both ends
package irs_pkg;

  // ==========================================================
  // clock and link timing
  localparam int CLK_MHZ = 40;
  localparam int SPIKE_STD_NS = 50;
  localparam int SPIKE_HS_NS = 10;
  localparam int FILT_STD_CYC = (SPIKE_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_HS_CYC = (SPIKE_HS_NS * CLK_MHZ + 999) / 1000;
  localparam int PWRUP_NS = 1000;
  localparam int PWRUP_CYC = (PWRUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STD_KHZ = 400;
  localparam int HS_KHZ = 3400;
  localparam int Q_STD_CYC = (CLK_MHZ * 1000 + STD_KHZ * 4 - 1) / (STD_KHZ * 4);
  localparam int Q_HS_CYC = (CLK_MHZ * 1000 + HS_KHZ * 4 - 1) / (HS_KHZ * 4);

  // ==========================================================
  // addressing
  localparam logic [2:0] ADDR_FIXED = 3'h4;
  localparam logic [6:0] ADDR_BCAST = 7'h3f;
  localparam logic [4:0] MCODE_TOP = 5'h01;
  localparam logic [2:0] MCODE_LOW = 3'h0;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_LAST = 8'h09;
  // strap level codes per select pin
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_VCC = 2'h1;
  localparam logic [1:0] STRAP_SDA = 2'h2;
  localparam logic [1:0] STRAP_SCL = 2'h3;

  // ==========================================================
  // state types
  typedef enum {SL_IDLE, SL_RX, SL_ACK, SL_LOAD, SL_TX, SL_TXACK} irs_sl_state_t;
  typedef enum {RL_ADDR, RL_PTR, RL_HI, RL_LO, RL_DONE} irs_role_t;
  typedef enum {H_IDLE, H_RUN} irs_h_state_t;
  typedef enum {OP_START, OP_TX, OP_RX, OP_STOP} irs_op_t;

endpackage

// >>> rtl/irs_master_end.sv
// bus master end: runs one register write or read per go_i pulse
// assumes the link has pull-ups and the slave never stretches the clock
`timescale 1ns/1ps
`default_nettype none
module irs_master_end
  import irs_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // request
  input wire logic go_i,
  input wire logic rd_i,
  input wire logic hs_i,
  input wire logic [6:0] dev_addr_i,
  input wire logic [7:0] ptr_i,
  input wire logic [15:0] wdata_i,
  // answer
  output logic busy_o,
  output logic done_o,
  output logic err_o,
  output logic [15:0] rdata_o,
  // link
  irs_link_if.master link
);

  // ==========================================================
  // sda synchroniser
  logic sda_m1;
  logic sda_s;
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sda_m1 <= 1'b1;
      sda_s <= 1'b1;
    end else if (ce_i) begin
      sda_m1 <= link.sda;
      sda_s <= sda_m1;
    end
  end

  // ==========================================================
  // request latch and step table
  irs_h_state_t st;
  logic [3:0] step;
  logic r_rd;
  logic r_hs;
  logic [6:0] r_addr;
  logic [7:0] r_ptr;
  logic [15:0] r_wd;
  irs_op_t op;
  logic [7:0] op_byte;
  logic op_ack;

  always_comb begin
    op = OP_STOP;
    op_byte = 8'h00;
    op_ack = 1'b0;
    case (step)
      4'h0: op = OP_START;
      4'h1: begin
        op = OP_TX;
        op_byte = {MCODE_TOP, MCODE_LOW};
      end
      4'h2: op = OP_START;
      4'h3: begin
        op = OP_TX;
        op_byte = {r_addr, 1'b0};
      end
      4'h4: begin
        op = OP_TX;
        op_byte = r_ptr;
      end
      4'h5: begin
        op = r_rd ? OP_START : OP_TX;
        op_byte = r_wd[15:8];
      end
      4'h6: begin
        op = OP_TX;
        op_byte = r_rd ? {r_addr, 1'b1} : r_wd[7:0];
      end
      4'h7: op = r_rd ? OP_RX : OP_STOP;
      4'h8: begin
        op = OP_RX;
        op_ack = 1'b1;
      end
      default: op = OP_STOP;
    endcase
  end

  // ==========================================================
  // quarter-bit timer; master code always goes at standard rate
  logic hs_now;
  logic [4:0] qc;
  logic [1:0] q;
  logic tick;
  logic [4:0] qlim;
  assign qlim = hs_now ? 5'(Q_HS_CYC) : 5'(Q_STD_CYC);
  assign tick = (st == H_RUN) && (qc == qlim - 5'h1);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      qc <= 5'h00;
    end else if (ce_i) begin
      qc <= (tick || st == H_IDLE) ? 5'h00 : qc + 5'h01;
    end
  end

  // ==========================================================
  // sequencer
  logic [3:0] bit_i;
  logic [7:0] rxb;
  logic scl_drv;
  logic sda_drv;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st <= H_IDLE;
      step <= 4'h0;
      q <= 2'h0;
      bit_i <= 4'h0;
      rxb <= 8'h00;
      scl_drv <= 1'b0;
      sda_drv <= 1'b0;
      hs_now <= 1'b0;
      r_rd <= 1'b0;
      r_hs <= 1'b0;
      r_addr <= 7'h00;
      r_ptr <= 8'h00;
      r_wd <= 16'h0000;
      done_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= 16'h0000;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (st == H_IDLE) begin
        if (go_i && rd_i && dev_addr_i == ADDR_BCAST) begin
          done_o <= 1'b1;
          err_o <= 1'b1;
        end else if (go_i) begin
          st <= H_RUN;
          step <= 4'h0;
          q <= 2'h0;
          bit_i <= 4'h0;
          err_o <= 1'b0;
          r_rd <= rd_i;
          r_hs <= hs_i;
          r_addr <= dev_addr_i;
          r_ptr <= ptr_i;
          r_wd <= wdata_i;
        end
      end else if (tick) begin
        q <= q + 2'h1;
        case (op)
          OP_START: begin
            case (q)
              2'h0: sda_drv <= 1'b0;
              2'h1: scl_drv <= 1'b0;
              2'h2: sda_drv <= 1'b1;
              default: begin
                scl_drv <= 1'b1;
                step <= (step == 4'h0 && !r_hs) ? 4'h3 : step + 4'h1;
              end
            endcase
          end
          OP_STOP: begin
            case (q)
              2'h0: sda_drv <= 1'b1;
              2'h1: scl_drv <= 1'b0;
              2'h2: sda_drv <= 1'b0;
              default: begin
                st <= H_IDLE;
                hs_now <= 1'b0;
                done_o <= 1'b1;
              end
            endcase
          end
          default: begin
            case (q)
              2'h0: begin
                if (bit_i == 4'h8) begin
                  sda_drv <= (op == OP_RX) && !op_ack;
                end else begin
                  sda_drv <= (op == OP_TX) && !op_byte[3'(4'h7 - bit_i)];
                end
              end
              2'h1: scl_drv <= 1'b0;
              2'h2: begin
                if (bit_i != 4'h8) begin
                  rxb <= {rxb[6:0], sda_s};
                end else if (op == OP_TX && sda_s && step != 4'h1) begin
                  err_o <= 1'b1;
                end
              end
              default: begin
                scl_drv <= 1'b1;
                if (bit_i == 4'h8) begin
                  bit_i <= 4'h0;
                  if (step == 4'h1) begin
                    hs_now <= 1'b1;
                  end
                  if (step == 4'h7) begin
                    rdata_o[15:8] <= rxb;
                  end
                  if (step == 4'h8) begin
                    rdata_o[7:0] <= rxb;
                  end
                  step <= err_o ? 4'h9 : step + 4'h1;
                end else begin
                  bit_i <= bit_i + 4'h1;
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  // ==========================================================
  // outputs
  assign busy_o = (st != H_IDLE);
  assign link.m_scl_o = 1'b0;
  assign link.m_scl_oe = scl_drv;
  assign link.m_sda_o = 1'b0;
  assign link.m_sda_oe = sda_drv;

endmodule
`default_nettype wire

// >>> rtl/irs_slave_end.sv
// slave end: serial port for 16-bit registers with 8-bit auto-incrementing pointer
// assumes the register bank sits on mclk_i and answers reg_rdata_i
// combinationally for reg_ptr_o
//
// How it works
// - write is start, id, pointer, two bytes, stop
// - first data byte is the upper half
// - acknowledge id, pointer and both write bytes
// - after a write, go idle until start
// - read is start, id-w, pointer, restart, id-r
// - acknowledge all three read command bytes
// - send upper then lower byte, lower only if acked
// - master ends read with no-ack then stop
// - pointer loads from pointer byte, increments per pair
// - pointers above 09h return zero
// - also answer the broadcast address on writes
// - master never reads through the broadcast address
// - master code 0000 1xxx requests fast mode
// - master code is sent at standard rate
// - fast mode shortens the input spike filter
// - stop leaves fast mode
// - repeated start keeps fast mode
// - own address from two four-level strap pins
// - address byte lsb one means read
// - pointer clears to 00h at reset
// - ignore the bus until start, and during power-up
`timescale 1ns/1ps
`default_nettype none
module irs_slave_end
  import irs_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // address strap pins, four-level codes
  input wire logic [1:0] addr_strap_pin_low_i,
  input wire logic [1:0] addr_strap_pin_high_i,
  // register bank side
  output logic reg_wr_o,
  output logic [7:0] reg_ptr_o,
  output logic [15:0] reg_wdata_o,
  input wire logic [15:0] reg_rdata_i,
  // status
  output logic hs_mode_o,
  // link
  irs_link_if.slave link
);

  // ==========================================================
  // pin synchronisers and spike filter
  logic [1:0] pin_raw;
  logic [1:0] filt;
  logic [1:0] fprev;
  logic [2:0] flim;
  logic hs;

  assign pin_raw = {link.scl, link.sda};
  // fast mode accepts shorter pulses on both lines
  assign flim = hs ? 3'(FILT_HS_CYC) : 3'(FILT_STD_CYC);

  for (genvar i = 0; i < 2; i++) begin : g_pin
    logic m1;
    logic m2;
    logic fq;
    logic [2:0] fc;
    always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
        m1 <= 1'b1;
        m2 <= 1'b1;
      end else if (ce_i) begin
        m1 <= pin_raw[i];
        m2 <= m1;
      end
    end
    always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
        fq <= 1'b1;
        fc <= 3'h0;
      end else if (ce_i) begin
        if (m2 == fq) begin
          fc <= 3'h0;
        end else if (fc + 3'h1 >= flim) begin
          fq <= m2;
          fc <= 3'h0;
        end else begin
          fc <= fc + 3'h1;
        end
      end
    end
    assign filt[i] = fq;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      fprev <= 2'h3;
    end else if (ce_i) begin
      fprev <= filt;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise = filt[1] && !fprev[1];
  assign scl_fall = !filt[1] && fprev[1];
  assign bus_start = filt[1] && fprev[1] && fprev[0] && !filt[0];
  assign bus_stop = filt[1] && fprev[1] && !fprev[0] && filt[0];

  // ==========================================================
  // power-up hold-off and strap capture
  logic [7:0] pwr_cnt;
  logic ready;
  logic [6:0] own_addr;

  assign ready = (pwr_cnt == 8'(PWRUP_CYC));

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pwr_cnt <= 8'h00;
    end else if (ce_i && !ready) begin
      pwr_cnt <= pwr_cnt + 8'h01;
    end
  end

  // straps are static; taken once, on the first enabled cycle after reset
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      own_addr <= {ADDR_FIXED, STRAP_GND, STRAP_GND};
    end else if (ce_i && pwr_cnt == 8'h00) begin
      own_addr <= {ADDR_FIXED, addr_strap_pin_high_i, addr_strap_pin_low_i};
    end
  end

  // ==========================================================
  // byte engine
  irs_sl_state_t st;
  irs_role_t role;
  logic [7:0] sh;
  logic [3:0] bcnt;
  logic rw;
  logic lo_phase;
  logic macked;
  logic sda_drv;
  logic [7:0] ptr;
  logic [7:0] hold;
  logic [15:0] txw;
  logic [15:0] rd_word;
  logic id_match;
  logic id_bcast;

  assign rd_word = (ptr > PTR_LAST) ? 16'h0000 : reg_rdata_i;
  assign id_match = (sh[7:1] == own_addr);
  // broadcast reads are refused so no two slaves ever drive data
  assign id_bcast = (sh[7:1] == ADDR_BCAST) && !sh[0];

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st <= SL_IDLE;
      role <= RL_ADDR;
      sh <= 8'h00;
      bcnt <= 4'h0;
      rw <= 1'b0;
      lo_phase <= 1'b0;
      macked <= 1'b0;
      sda_drv <= 1'b0;
      ptr <= PTR_RESET;
      hold <= 8'h00;
      txw <= 16'h0000;
      hs <= 1'b0;
      reg_wr_o <= 1'b0;
      reg_wdata_o <= 16'h0000;
    end else if (ce_i) begin
      reg_wr_o <= 1'b0;
      // pointer steps one cycle after the pulse so the bank writes the addressed word
      if (reg_wr_o) begin
        ptr <= ptr + 8'h01;
      end
      if (!ready) begin
        st <= SL_IDLE;
      end else if (bus_stop) begin
        st <= SL_IDLE;
        sda_drv <= 1'b0;
        hs <= 1'b0;
      end else if (bus_start) begin
        // a repeated start leaves hs untouched
        st <= SL_RX;
        role <= RL_ADDR;
        bcnt <= 4'h0;
        sda_drv <= 1'b0;
      end else begin
        case (st)
          SL_IDLE: begin
          end
          SL_RX: begin
            if (scl_rise) begin
              sh <= {sh[6:0], filt[0]};
              bcnt <= bcnt + 4'h1;
            end else if (scl_fall && bcnt == 4'h8) begin
              bcnt <= 4'h0;
              case (role)
                RL_ADDR: begin
                  if (sh[7:3] == MCODE_TOP) begin
                    // master code is never acknowledged
                    hs <= 1'b1;
                    st <= SL_IDLE;
                  end else if (id_match || id_bcast) begin
                    st <= SL_ACK;
                    sda_drv <= 1'b1;
                    rw <= sh[0];
                    role <= sh[0] ? RL_DONE : RL_PTR;
                  end else begin
                    st <= SL_IDLE;
                  end
                end
                RL_PTR: begin
                  ptr <= sh;
                  role <= RL_HI;
                  st <= SL_ACK;
                  sda_drv <= 1'b1;
                end
                RL_HI: begin
                  hold <= sh;
                  role <= RL_LO;
                  st <= SL_ACK;
                  sda_drv <= 1'b1;
                end
                default: begin
                  reg_wdata_o <= {hold, sh};
                  role <= RL_DONE;
                  st <= SL_ACK;
                  sda_drv <= 1'b1;
                end
              endcase
            end
          end
          SL_ACK: begin
            if (scl_fall) begin
              sda_drv <= 1'b0;
              if (rw) begin
                lo_phase <= 1'b0;
                st <= SL_LOAD;
              end else if (role == RL_DONE) begin
                // commit only once the second byte is acknowledged
                reg_wr_o <= 1'b1;
                st <= SL_IDLE;
              end else begin
                st <= SL_RX;
              end
            end
          end
          SL_LOAD: begin
            txw <= rd_word;
            sda_drv <= !rd_word[15];
            bcnt <= 4'h0;
            st <= SL_TX;
          end
          SL_TX: begin
            if (scl_fall) begin
              txw <= {txw[14:0], 1'b0};
              if (bcnt == 4'h7) begin
                sda_drv <= 1'b0;
                bcnt <= 4'h0;
                st <= SL_TXACK;
              end else begin
                sda_drv <= !txw[14];
                bcnt <= bcnt + 4'h1;
              end
            end
          end
          SL_TXACK: begin
            if (scl_rise) begin
              macked <= !filt[0];
            end else if (scl_fall) begin
              if (lo_phase) begin
                ptr <= ptr + 8'h01;
                lo_phase <= 1'b0;
                st <= macked ? SL_LOAD : SL_IDLE;
              end else if (macked) begin
                lo_phase <= 1'b1;
                sda_drv <= !txw[15];
                st <= SL_TX;
              end else begin
                st <= SL_IDLE;
              end
            end
          end
          default: begin
            st <= SL_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // outputs
  assign reg_ptr_o = ptr;
  assign hs_mode_o = hs;
  assign link.s_sda_o = 1'b0;
  assign link.s_sda_oe = sda_drv;

endmodule
`default_nettype wire

// >>> test/irs_link_sva.sv
// checker for the two-wire link between master end and slave end
// assumes one 40 MHz clock domain and the synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module irs_link_sva (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // link lines and drivers
  input wire logic scl,
  input wire logic sda,
  input wire logic m_scl_oe,
  input wire logic s_sda_oe,
  // slave register side
  input wire logic reg_wr_o,
  input wire logic [7:0] reg_ptr_o,
  input wire logic hs_mode_o
);
  // ==========================================================
  // properties
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  quiet_power_up_a: assert property ($fell(sys_rst_i) |-> !s_sda_oe [*8])
    else $error("slave drove data during power-up");
  ptr_cleared_a: assert property ($fell(sys_rst_i) |-> reg_ptr_o == 8'h00)
    else $error("pointer not cleared by reset");
  fast_exit_idle_a: assert property ($fell(hs_mode_o) |-> scl && sda)
    else $error("fast mode left while bus busy");
  write_single_a: assert property (reg_wr_o |=> !reg_wr_o)
    else $error("register write longer than one cycle");
  write_clock_low_a: assert property (reg_wr_o |-> !scl)
    else $error("register write outside clock low phase");
  ack_starts_low_a: assert property ($rose(s_sda_oe) |-> !scl)
    else $error("slave drive began with clock high");
  data_held_high_a: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("slave data changed with clock high");
  clock_low_hold_a: assert property ($rose(m_scl_oe) |-> m_scl_oe [*6])
    else $error("clock low phase too short");
endmodule
`default_nettype wire

// >>> test/test_i2c_register_slave_port.sv
// testbench: master end and slave end joined by one link, register bank modelled here
// assumes the shared package and link interface are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(got, exp) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_i2c_register_slave_port;
  // straps high=scl, low=sda give 100_1110
  localparam logic [6:0] OWN_ADDR = 7'h4e;
  localparam logic [6:0] OTHER_ADDR = 7'h40;
  localparam logic [6:0] BCAST = 7'h3f;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [1:0] strap_lo = irs_pkg::STRAP_SDA;
  logic [1:0] strap_hi = irs_pkg::STRAP_SCL;
  logic go_i = 1'b0;
  logic rd_i = 1'b0;
  logic hs_i = 1'b0;
  logic [6:0] dev_addr_i = 7'h00;
  logic [7:0] ptr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic busy_o, done_o, err_o, reg_wr_o, hs_mode_o;
  logic [15:0] rdata_o, reg_wdata_o, reg_rdata_i;
  logic [7:0] reg_ptr_o;
  logic [15:0] regs [16];
  logic [15:0] rd_v;
  logic er_v;
  logic hs_seen = 1'b0;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic [7:0] sh = 8'h00;
  logic [7:0] last_id = 8'h00;
  logic [7:0] rp [4] = '{8'h03, 8'h09, 8'h0a, 8'hff};
  logic [15:0] re [4] = '{16'ha5c3, 16'h1009, 16'h0000, 16'h0000};
  int bit_n = 9;
  int wr_count = 0;
  int wr_base;
  int fail_count = 0;
  int n_checks = 0;

  // ==========================================================
  // structure
  irs_link_if link ();
  irs_master_end u_irs_master_end (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .go_i(go_i), .rd_i(rd_i), .hs_i(hs_i), .dev_addr_i(dev_addr_i), .ptr_i(ptr_i),
    .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o), .err_o(err_o),
    .rdata_o(rdata_o), .link(link));
  irs_slave_end u_irs_slave_end (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .addr_strap_pin_low_i(strap_lo), .addr_strap_pin_high_i(strap_hi),
    .reg_wr_o(reg_wr_o), .reg_ptr_o(reg_ptr_o), .reg_wdata_o(reg_wdata_o),
    .reg_rdata_i(reg_rdata_i), .hs_mode_o(hs_mode_o), .link(link));
  irs_link_sva u_irs_link_sva (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .scl(link.scl),
    .sda(link.sda), .m_scl_oe(link.m_scl_oe), .s_sda_oe(link.s_sda_oe),
    .reg_wr_o(reg_wr_o), .reg_ptr_o(reg_ptr_o), .hs_mode_o(hs_mode_o));

  always #12.5 mclk_i = ~mclk_i;

  // ==========================================================
  // register bank and wire monitor
  // full 16-entry bank so the slave, not the bank, must blank high pointers
  assign reg_rdata_i = regs[reg_ptr_o[3:0]];
  always @(posedge mclk_i) begin
    if (reg_wr_o === 1'b1) begin
      wr_count++;
      regs[reg_ptr_o[3:0]] <= reg_wdata_o;
    end
    if (hs_mode_o === 1'b1) hs_seen <= 1'b1;
  end
  // keeps the first byte after the latest start, msb first
  always @(posedge mclk_i) begin
    scl_q <= link.scl;
    sda_q <= link.sda;
    if (scl_q && link.scl && sda_q && !link.sda) begin
      bit_n <= 0;
    end else if (!scl_q && link.scl && bit_n < 8) begin
      sh <= {sh[6:0], link.sda};
      bit_n <= bit_n + 1;
      if (bit_n == 7) last_id <= {sh[6:0], link.sda};
    end
  end

  // ==========================================================
  // tasks
  task automatic xfer(input logic rd, input logic hs, input logic [6:0] a,
      input logic [7:0] p, input logic [15:0] w, output logic [15:0] rdat, output logic er);
    int n;
    n = 0;
    hs_seen = 1'b0;
    @(posedge mclk_i);
    go_i <= 1'b1;
    rd_i <= rd;
    hs_i <= hs;
    dev_addr_i <= a;
    ptr_i <= p;
    wdata_i <= w;
    @(posedge mclk_i);
    go_i <= 1'b0;
    @(negedge mclk_i);
    while (done_o !== 1'b1 && n < 20000) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 20000) fail_count++;
    // in fast mode the slave sees the stop one cycle after the master reports done
    repeat (8) @(negedge mclk_i);
    rdat = rdata_o;
    er = err_o;
  endtask

  task automatic after_xfer(input logic er_exp, input logic [7:0] ptr_exp,
      input logic [7:0] id_exp);
    `CHECK_EQ(er_v, er_exp)
    `CHECK_EQ(reg_ptr_o, ptr_exp)
    `CHECK_EQ(last_id, id_exp)
    `CHECK_EQ({link.scl, link.sda}, 2'b11)
    `CHECK_EQ(busy_o, 1'b0)
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    #2_000_000;
    fail_count++;
    stop_test();
  end

  initial begin
    for (int i = 0; i < 16; i++) regs[i] = 16'h1000 + 16'(i);
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(negedge mclk_i);
    `CHECK_EQ(reg_ptr_o, 8'h00)
    `CHECK_EQ(hs_mode_o, 1'b0)
    repeat (50) @(posedge mclk_i);
    wr_base = wr_count;
    xfer(1'b0, 1'b0, OWN_ADDR, 8'h03, 16'ha5c3, rd_v, er_v);
    after_xfer(1'b0, 8'h04, {OWN_ADDR, 1'b0});
    `CHECK_EQ(wr_count, wr_base + 1)
    `CHECK_EQ(regs[3], 16'ha5c3)
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 1'b0, OWN_ADDR, rp[i], 16'h0000, rd_v, er_v);
      `CHECK_EQ(rd_v, re[i])
      after_xfer(1'b0, rp[i] + 8'h01, {OWN_ADDR, 1'b1});
    end
    wr_base = wr_count;
    xfer(1'b0, 1'b0, OTHER_ADDR, 8'h02, 16'h1234, rd_v, er_v);
    `CHECK_EQ(er_v, 1'b1)
    `CHECK_EQ(wr_count, wr_base)
    xfer(1'b0, 1'b0, BCAST, 8'h05, 16'h5aa5, rd_v, er_v);
    after_xfer(1'b0, 8'h06, {BCAST, 1'b0});
    `CHECK_EQ(regs[5], 16'h5aa5)
    xfer(1'b1, 1'b0, BCAST, 8'h05, 16'h0000, rd_v, er_v);
    `CHECK_EQ(er_v, 1'b1)
    xfer(1'b0, 1'b1, OWN_ADDR, 8'h06, 16'hbeef, rd_v, er_v);
    after_xfer(1'b0, 8'h07, {OWN_ADDR, 1'b0});
    `CHECK_EQ(hs_seen, 1'b1)
    `CHECK_EQ(hs_mode_o, 1'b0)
    `CHECK_EQ(regs[6], 16'hbeef)
    xfer(1'b1, 1'b1, OWN_ADDR, 8'h06, 16'h0000, rd_v, er_v);
    `CHECK_EQ(rd_v, 16'hbeef)
    after_xfer(1'b0, 8'h07, {OWN_ADDR, 1'b1});
    `CHECK_EQ(hs_seen, 1'b1)
    `CHECK_EQ(hs_mode_o, 1'b0)
    stop_test();
  end
endmodule
`default_nettype wire
